// File: hdl/lldr_pkg.sv
package lldr_pkg;

   localparam int ADDR_W   = 22;
   localparam int BANK_W   = 3;
   localparam int IMP_W    = 6;
   localparam int WHEEL_AW = 4;
   localparam int WHEEL_N  = 16;

   // Mode field positions, direct address mode
   localparam int MR_CFG_LSB  = 0;
   localparam int MR_CFG_W    = 3;
   localparam int MR_BL_LSB   = 3;
   localparam int MR_BL_W     = 2;
   localparam int MR_AM_BIT   = 5;
   localparam int MR_DLL_BIT  = 7;
   localparam int MR_IMP_BIT  = 8;
   localparam int MR_TERM_BIT = 9;
   // Mode fields carried by the second part in multiplexed mode
   localparam int SECOND_CFG_MID = 3;
   localparam int SECOND_CFG_HI  = 4;
   localparam int SECOND_DLL     = 9;

   localparam logic [2:0] MR_CFG_RST  = 3'h0;
   localparam logic [1:0] MR_BL_RST   = 2'h0;
   localparam logic       MR_AM_RST   = 1'b0;
   localparam logic       MR_DLL_RST  = 1'b0;
   localparam logic       MR_IMP_RST  = 1'b0;
   localparam logic       MR_TERM_RST = 1'b0;

   localparam logic [2:0] CFG_2 = 3'h2;
   localparam logic [2:0] CFG_3 = 3'h3;
   localparam logic [2:0] CFG_4 = 3'h4;
   localparam logic [2:0] CFG_5 = 3'h5;
   localparam logic [3:0] RL_CFG_1 = 4'h4;
   localparam logic [3:0] RL_CFG_2 = 4'h6;
   localparam logic [3:0] RL_CFG_3 = 4'h8;
   localparam logic [3:0] RL_CFG_4 = 4'h3;
   localparam logic [3:0] RL_CFG_5 = 4'h5;
   localparam logic [3:0] MUX_EXTRA_LAT   = 4'h1;
   localparam logic [3:0] WRITE_EXTRA_LAT = 4'h1;

   localparam logic [1:0] BL_2 = 2'h0;
   localparam logic [1:0] BL_4 = 2'h1;
   localparam logic [1:0] BL_8 = 2'h2;
   localparam logic [2:0] BURST_CYC_2 = 3'h1;
   localparam logic [2:0] BURST_CYC_4 = 3'h2;
   localparam logic [2:0] BURST_CYC_8 = 3'h4;

   localparam int DLL_CNT_W = 11;
   localparam logic [DLL_CNT_W-1:0] DLL_LOCK_CYCLES = 11'h400;

   localparam int SYS_CLK_KHZ      = 10000;
   localparam int CAL_INTERVAL_US  = 100;
   localparam int CAL_INTERVAL_CYC = CAL_INTERVAL_US * SYS_CLK_KHZ / 1000;
   localparam int CAL_TIMER_W      = 10;
   localparam logic [IMP_W-1:0] IMP_CODE_RST = 6'h20;

   // Balls used by the first part; second part mapping per target bit
   localparam logic [ADDR_W-1:0] FIRST_BALLS = 22'h066739;
   localparam int SECOND_BALL [ADDR_W] = '{
      -1, 3, 4, -1, -1, -1, 8, 9, -1, -1, -1,
      13, 14, -1, -1, 18, 17, -1, -1, 10, 0, 5};

   typedef enum logic [4:0] {
      CMD_IDLE     = 5'h01,
      CMD_MODE_SET = 5'h02,
      CMD_READ     = 5'h04,
      CMD_WRITE    = 5'h08,
      CMD_REFRESH  = 5'h10
   } lldr_cmd_t;

   function automatic logic [3:0] lldr_read_latency(
      input logic [2:0] cfg,
      input logic       mux);
      logic [3:0] base;
      unique case (cfg)
         CFG_2:   base = RL_CFG_2;
         CFG_3:   base = RL_CFG_3;
         CFG_4:   base = RL_CFG_4;
         CFG_5:   base = RL_CFG_5;
         default: base = RL_CFG_1;
      endcase
      return mux ? base + MUX_EXTRA_LAT : base;
   endfunction : lldr_read_latency

   function automatic logic [2:0] lldr_burst_cycles(input logic [1:0] bl);
      unique case (bl)
         BL_4:    return BURST_CYC_4;
         BL_8:    return BURST_CYC_8;
         default: return BURST_CYC_2;
      endcase
   endfunction : lldr_burst_cycles

   function automatic logic [ADDR_W-1:0] lldr_join_addr(
      input logic [ADDR_W-1:0] first,
      input logic [ADDR_W-1:0] second);
      logic [ADDR_W-1:0] full;
      full = first & FIRST_BALLS;
      for (int i = 0; i < ADDR_W; i++) begin
         if (SECOND_BALL[i] >= 0) full[i] = second[SECOND_BALL[i]];
      end
      return full;
   endfunction : lldr_join_addr

endpackage : lldr_pkg

// File: hdl/lldr_word_sync.sv
`timescale 1ns/1ps
module lldr_word_sync
   import lldr_pkg::*;
#(
   parameter int               W       = IMP_W,
   parameter logic [W-1:0]     RST_VAL = IMP_CODE_RST
) (
   input  wire logic         src_clk,
   input  wire logic         src_rst,
   input  wire logic [W-1:0] src_word,
   input  wire logic         dst_clk,
   input  wire logic         dst_rst,
   output logic      [W-1:0] dst_word
);
   logic         req_tgl;
   logic [W-1:0] hold;
   logic         ack_meta;
   logic         ack_sync;
   logic         req_meta;
   logic         req_sync;
   logic         req_seen;

   // Hold is stable whenever a request is outstanding
   always_ff @(posedge src_clk) begin
      if (src_rst) begin
         req_tgl  <= 1'b0;
         hold     <= RST_VAL;
         ack_meta <= 1'b0;
         ack_sync <= 1'b0;
      end else begin
         ack_meta <= req_seen;
         ack_sync <= ack_meta;
         if (ack_sync == req_tgl && src_word != hold) begin
            hold    <= src_word;
            req_tgl <= ~req_tgl;
         end
      end
   end

   always_ff @(posedge dst_clk) begin
      if (dst_rst) begin
         req_meta <= 1'b0;
         req_sync <= 1'b0;
         req_seen <= 1'b0;
         dst_word <= RST_VAL;
      end else begin
         req_meta <= req_tgl;
         req_sync <= req_meta;
         if (req_sync != req_seen) begin
            req_seen <= req_sync;
            dst_word <= hold;
         end
      end
   end
endmodule : lldr_word_sync

// File: hdl/lldr_imp_cal.sv
`timescale 1ns/1ps
module lldr_imp_cal
   import lldr_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             ext_sel,
   input  wire logic             impedance_resistor_cmp,
   output logic                  impedance_ball_sel,
   output logic      [IMP_W-1:0] code
);
   logic                   sel_meta;
   logic                   sel_sync;
   logic                   cmp_meta;
   logic                   cmp_sync;
   logic [CAL_TIMER_W-1:0] timer;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sel_meta <= 1'b0;
         sel_sync <= 1'b0;
         cmp_meta <= 1'b0;
         cmp_sync <= 1'b0;
      end else begin
         sel_meta <= ext_sel;
         sel_sync <= sel_meta;
         cmp_meta <= impedance_resistor_cmp;
         cmp_sync <= cmp_meta;
      end
   end

   // Comparator high means the driver is too weak: step strength up
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         timer              <= '0;
         code               <= IMP_CODE_RST;
         impedance_ball_sel <= 1'b0;
      end else begin
         impedance_ball_sel <= sel_sync;
         if (timer == '0) begin
            timer <= CAL_TIMER_W'(CAL_INTERVAL_CYC - 1);
            if (cmp_sync && code != '1) begin
               code <= code + 1'b1;
            end else if (!cmp_sync && code != '0) begin
               code <= code - 1'b1;
            end
         end else begin
            timer <= timer - 1'b1;
         end
      end
   end
endmodule : lldr_imp_cal

// File: hdl/lldr_top.sv
`timescale 1ns/1ps
module lldr_top
   import lldr_pkg::*;
#(
   parameter int DQ_W   = 18,
   parameter int MEM_AW = 8
) (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              link_clk,
   input  wire logic              cs_n,
   input  wire logic              we_n,
   input  wire logic              ref_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [BANK_W-1:0] bank,
   input  wire logic [DQ_W-1:0]   write_data_rise,
   input  wire logic [DQ_W-1:0]   write_data_fall,
   input  wire logic              write_mask_rise,
   input  wire logic              write_mask_fall,
   input  wire logic              clock_fault,
   input  wire logic              impedance_resistor_cmp,
   output logic      [DQ_W-1:0]   read_data_rise,
   output logic      [DQ_W-1:0]   read_data_fall,
   output logic                   read_data_oe,
   output logic                   read_data_valid,
   output logic                   read_data_clock,
   output logic                   read_data_clock_n,
   output logic                   dq_on_die_termination,
   output logic                   mask_on_die_termination,
   output logic                   impedance_ball_sel,
   output logic      [IMP_W-1:0]  drive_code,
   output logic                   dll_enabled,
   output logic                   dll_locked,
   output logic                   addr_mux_mode,
   output logic                   refresh_strobe,
   output logic      [BANK_W-1:0] refresh_bank
);
   localparam logic [MEM_AW-1:0] ONE_WORD  = 1;
   localparam logic [MEM_AW-1:0] TWO_WORDS = 2;

   logic                 lrst_meta;
   logic                 lrst;
   logic                 fault_meta;
   logic                 fault_sync;
   lldr_cmd_t            cmd;
   lldr_cmd_t            phase2_cmd;
   logic                 addr_phase2;
   logic [ADDR_W-1:0]    first_addr;
   logic [BANK_W-1:0]    first_bank;
   logic [ADDR_W-1:0]    full_addr;
   logic [BANK_W-1:0]    full_bank;
   logic                 issue_rd;
   logic                 issue_wr;
   logic                 mode_set2;
   logic [3:0]           rl;
   logic [3:0]           rd_delay;
   logic [3:0]           wr_delay;
   logic [MEM_AW-1:0]    issue_idx;
   logic [2:0]           cfg;
   logic [1:0]           bl;
   logic                 imp_ext;
   logic                 term_en;
   logic [DLL_CNT_W-1:0] dll_cnt;
   logic [IMP_W-1:0]     cal_code;
   logic [WHEEL_AW-1:0]  wptr;
   logic [WHEEL_N-1:0]   rd_due;
   logic [WHEEL_N-1:0]   wr_due;
   logic [MEM_AW-1:0]    rd_idx [WHEEL_N];
   logic [MEM_AW-1:0]    wr_idx [WHEEL_N];
   logic [DQ_W-1:0]      mem    [2**MEM_AW];
   logic [2:0]           beats;
   logic                 rd_start;
   logic                 wr_start;
   logic [2:0]           rd_left;
   logic [2:0]           wr_left;
   logic [MEM_AW-1:0]    rd_ptr;
   logic [MEM_AW-1:0]    wr_ptr;
   logic [MEM_AW-1:0]    rd_at;
   logic [MEM_AW-1:0]    wr_at;
   logic                 next_oe;
   logic                 wr_beat;
   logic                 rd_next;
   logic                 fault_hold;
   logic                 clk_rise;
   logic                 clk_fall;

   // Link-side reset and clock fault brought onto the link clock
   always_ff @(posedge link_clk) begin
      lrst_meta <= rst;
      lrst      <= lrst_meta;
   end

   always_ff @(posedge link_clk) begin
      if (lrst) begin
         fault_meta <= 1'b0;
         fault_sync <= 1'b0;
      end else begin
         fault_meta <= clock_fault;
         fault_sync <= fault_meta;
      end
   end

   // Command decode; the second address cycle is never a command
   always_comb begin
      cmd = CMD_IDLE;
      if (!cs_n && !addr_phase2) begin
         unique case ({we_n, ref_n})
            2'b00: cmd = CMD_MODE_SET;
            2'b11: cmd = CMD_READ;
            2'b01: cmd = CMD_WRITE;
            2'b10: cmd = CMD_REFRESH;
         endcase
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst) begin
         addr_phase2 <= 1'b0;
         phase2_cmd  <= CMD_IDLE;
         first_addr  <= '0;
         first_bank  <= '0;
      end else begin
         addr_phase2 <= addr_mux_mode && (cmd == CMD_READ ||
                        cmd == CMD_WRITE || cmd == CMD_MODE_SET);
         phase2_cmd  <= cmd;
         if (cmd != CMD_IDLE) begin
            first_addr <= addr;
            first_bank <= bank;
         end
      end
   end

   // Address complete: at the command, or one edge later when split
   always_comb begin
      rl = lldr_read_latency(cfg, addr_mux_mode);
      if (addr_phase2) begin
         full_addr = lldr_join_addr(first_addr, addr);
         full_bank = first_bank;
         issue_rd  = phase2_cmd == CMD_READ;
         issue_wr  = phase2_cmd == CMD_WRITE;
         mode_set2 = phase2_cmd == CMD_MODE_SET;
         rd_delay  = rl - MUX_EXTRA_LAT;
      end else begin
         full_addr = addr;
         full_bank = bank;
         issue_rd  = cmd == CMD_READ && !addr_mux_mode;
         issue_wr  = cmd == CMD_WRITE && !addr_mux_mode;
         mode_set2 = 1'b0;
         rd_delay  = rl;
      end
      wr_delay  = rd_delay + WRITE_EXTRA_LAT;
      issue_idx = {full_bank, full_addr[MEM_AW-BANK_W-1:0]};
   end

   // Mode register
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         cfg           <= MR_CFG_RST;
         bl            <= MR_BL_RST;
         addr_mux_mode <= MR_AM_RST;
         dll_enabled   <= MR_DLL_RST;
         imp_ext       <= MR_IMP_RST;
         term_en       <= MR_TERM_RST;
      end else if (cmd == CMD_MODE_SET && !addr_mux_mode) begin
         cfg           <= addr[MR_CFG_LSB +: MR_CFG_W];
         bl            <= addr[MR_BL_LSB +: MR_BL_W];
         addr_mux_mode <= addr[MR_AM_BIT];
         dll_enabled   <= addr[MR_DLL_BIT];
         imp_ext       <= addr[MR_IMP_BIT];
         term_en       <= addr[MR_TERM_BIT];
      end else if (mode_set2) begin
         cfg           <= {addr[SECOND_CFG_HI], addr[SECOND_CFG_MID],
                           first_addr[MR_CFG_LSB]};
         bl            <= first_addr[MR_BL_LSB +: MR_BL_W];
         addr_mux_mode <= first_addr[MR_AM_BIT];
         dll_enabled   <= addr[SECOND_DLL];
         imp_ext       <= first_addr[MR_IMP_BIT];
         term_en       <= first_addr[MR_TERM_BIT];
      end
   end

   // Clock loop lock timer restarts each time the loop is enabled
   always_ff @(posedge link_clk) begin
      if (lrst || !dll_enabled) begin
         dll_cnt    <= '0;
         dll_locked <= 1'b0;
      end else if (!dll_locked) begin
         dll_cnt    <= dll_cnt + 1'b1;
         dll_locked <= dll_cnt == DLL_LOCK_CYCLES - 1'b1;
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst) begin
         refresh_strobe <= 1'b0;
         refresh_bank   <= '0;
      end else begin
         refresh_strobe <= cmd == CMD_REFRESH;
         if (cmd == CMD_REFRESH) begin
            refresh_bank <= bank;
         end
      end
   end

   // Timing wheel: one slot per edge, due reads and writes by latency
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         wptr   <= '0;
         rd_due <= '0;
         wr_due <= '0;
      end else begin
         wptr         <= wptr + 1'b1;
         rd_due[wptr] <= 1'b0;
         wr_due[wptr] <= 1'b0;
         if (issue_rd) begin
            rd_due[wptr + rd_delay[WHEEL_AW-1:0]] <= 1'b1;
            rd_idx[wptr + rd_delay[WHEEL_AW-1:0]] <= issue_idx;
         end
         if (issue_wr) begin
            wr_due[wptr + wr_delay[WHEEL_AW-1:0]] <= 1'b1;
            wr_idx[wptr + wr_delay[WHEEL_AW-1:0]] <= issue_idx;
         end
      end
   end

   always_comb begin
      beats    = lldr_burst_cycles(bl);
      rd_start = rd_due[wptr];
      wr_start = wr_due[wptr];
      rd_at    = rd_start ? rd_idx[wptr] : rd_ptr;
      wr_at    = wr_start ? wr_idx[wptr] : wr_ptr;
      next_oe  = rd_start || rd_left != '0;
      wr_beat  = wr_start || wr_left != '0;
   end

   // Read bursts; a due read starts even as the last one ends
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         rd_left        <= '0;
         rd_ptr         <= '0;
         read_data_oe   <= 1'b0;
         read_data_rise <= '0;
         read_data_fall <= '0;
         rd_next        <= 1'b0;
      end else begin
         read_data_oe <= next_oe;
         if (next_oe) begin
            read_data_rise <= mem[rd_at];
            read_data_fall <= mem[rd_at + ONE_WORD];
            rd_ptr         <= rd_at + TWO_WORDS;
         end
         if (rd_start) begin
            rd_left <= beats - 1'b1;
         end else if (rd_left != '0) begin
            rd_left <= rd_left - 1'b1;
         end
         rd_next <= (rd_start ? beats > 3'h1 : rd_left > 3'h1) ||
                    rd_due[wptr + 1'b1];
      end
   end

   // Write bursts; a masked rise or fall word leaves its array entry untouched
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         wr_left <= '0;
         wr_ptr  <= '0;
      end else begin
         if (wr_beat) begin
            wr_ptr <= wr_at + TWO_WORDS;
         end
         if (wr_start) begin
            wr_left <= beats - 1'b1;
         end else if (wr_left != '0) begin
            wr_left <= wr_left - 1'b1;
         end
      end
   end

   always_ff @(posedge link_clk) begin
      if (wr_beat && !write_mask_rise) begin
         mem[wr_at] <= write_data_rise;
      end
      if (wr_beat && !write_mask_fall) begin
         mem[wr_at + ONE_WORD] <= write_data_fall;
      end
   end

   // A clock fault mid burst pins valid high until the next read
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         fault_hold <= 1'b0;
      end else if (fault_sync && (read_data_oe || rd_next)) begin
         fault_hold <= 1'b1;
      end else if (cmd == CMD_READ) begin
         fault_hold <= 1'b0;
      end
   end

   // Valid moves on the falling edge: half a cycle early, or last beat
   always_ff @(negedge link_clk) begin
      if (lrst) begin
         read_data_valid <= 1'b0;
      end else begin
         read_data_valid <= rd_next || fault_hold;
      end
   end

   // Only data and mask pins ever carry termination
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         dq_on_die_termination   <= 1'b0;
         mask_on_die_termination <= 1'b0;
      end else begin
         dq_on_die_termination   <= term_en && !next_oe;
         mask_on_die_termination <= term_en;
      end
   end

   // Forwarded data clock from two toggles, aligned to data edges
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         clk_rise <= 1'b0;
      end else begin
         clk_rise <= ~clk_rise;
      end
   end

   always_ff @(negedge link_clk) begin
      if (lrst) begin
         clk_fall <= 1'b0;
      end else begin
         clk_fall <= ~clk_fall;
      end
   end

   assign read_data_clock   = clk_rise ^ clk_fall;
   assign read_data_clock_n = ~(clk_rise ^ clk_fall);

   // Calibration runs on the system clock, apart from the command path
   lldr_imp_cal u_cal (
      .sys_clk                (sys_clk),
      .rst                    (rst),
      .ext_sel                (imp_ext),
      .impedance_resistor_cmp (impedance_resistor_cmp),
      .impedance_ball_sel     (impedance_ball_sel),
      .code                   (cal_code)
   );

   lldr_word_sync #(
      .W       (IMP_W),
      .RST_VAL (IMP_CODE_RST)
   ) u_code_sync (
      .src_clk  (sys_clk),
      .src_rst  (rst),
      .src_word (cal_code),
      .dst_clk  (link_clk),
      .dst_rst  (lrst),
      .dst_word (drive_code)
   );
endmodule : lldr_top

// File: testbench/lldr_ctrl_model.sv
`timescale 1ns/1ps
module lldr_ctrl_model
   import lldr_pkg::*;
(
   input  wire logic              link_clk,
   output logic                   cs_n,
   output logic                   we_n,
   output logic                   ref_n,
   output logic      [ADDR_W-1:0] addr,
   output logic      [BANK_W-1:0] bank
);
   initial begin
      cs_n = 1'b1;
      {we_n, ref_n} = 2'h3;
      addr = '0;
      bank = '0;
   end
   // While deselected, we_n, addr and bank keep moving so nothing stale looks valid
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge link_clk) #1;
         cs_n = 1'b1;
         we_n = ~we_n;
         addr = ~addr;
         bank = ~bank;
      end
   endtask : idle
   task automatic op(input logic [1:0] c, input logic [ADDR_W-1:0] a1,
                     input logic [ADDR_W-1:0] a2, input logic [2:0] b,
                     input logic two);
      @(posedge link_clk) #1;
      cs_n = 1'b0;
      {we_n, ref_n} = c;
      addr = a1;
      bank = b;
      if (two) begin
         @(posedge link_clk) #1;
         cs_n = 1'b1;
         addr = a2;
         bank = ~bank;
      end
   endtask : op
endmodule : lldr_ctrl_model

// File: testbench/lldr_checker.sv
`timescale 1ns/1ps
module lldr_checker (
   input wire logic link_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic we_n,
   input wire logic ref_n,
   input wire logic read_data_oe,
   input wire logic read_data_valid,
   input wire logic dq_on_die_termination,
   input wire logic mask_on_die_termination,
   input wire logic dll_enabled,
   input wire logic dll_locked,
   input wire logic refresh_strobe
);
   default clocking @(posedge link_clk); endclocking
   default disable iff (rst);
   logic [10:0] lock_cnt;
   always_ff @(posedge link_clk) begin
      if (rst || !dll_enabled) lock_cnt <= 11'h000;
      else if (lock_cnt != 11'h7FF) lock_cnt <= lock_cnt + 11'h001;
   end
   property p_loop_off; !dll_enabled |-> !dll_locked; endproperty
   a_loop_off: assert property (p_loop_off) else $error("lock no loop");
   property p_lock; $rose(dll_locked) |-> lock_cnt inside {[11'h3FE:11'h402]};
   endproperty
   a_lock: assert property (p_lock) else $error("lock time");
   property p_lat; !cs_n && we_n && ref_n |-> ##[3:10] read_data_valid;
   endproperty
   a_lat: assert property (p_lat) else $error("no valid");
   property p_lead; $rose(read_data_valid) |-> !read_data_oe ##1 read_data_oe;
   endproperty
   a_lead: assert property (p_lead) else $error("valid lead");
   property p_fall; $fell(read_data_valid) |-> read_data_oe; endproperty
   a_fall: assert property (p_fall) else $error("valid fall");
   property p_float; read_data_oe && !read_data_valid |=> !read_data_oe;
   endproperty
   a_float: assert property (p_float) else $error("no float");
   property p_toff; read_data_oe |-> !dq_on_die_termination; endproperty
   a_toff: assert property (p_toff) else $error("term on");
   property p_tback; $fell(read_data_oe) |->
      dq_on_die_termination == mask_on_die_termination; endproperty
   a_tback: assert property (p_tback) else $error("term back");
   property p_ref; !cs_n && we_n && !ref_n |-> ##[1:2] refresh_strobe;
   endproperty
   a_ref: assert property (p_ref) else $error("no refresh");
   c_stream: cover property (read_data_valid [*6]);
   c_lock: cover property ($rose(dll_locked));
   c_ref: cover property (refresh_strobe ##1 refresh_strobe);
endmodule : lldr_checker
bind lldr_top lldr_checker u_chk (.link_clk(link_clk), .rst(rst),
   .cs_n(cs_n), .we_n(we_n), .ref_n(ref_n), .read_data_oe(read_data_oe),
   .read_data_valid(read_data_valid), .dll_enabled(dll_enabled),
   .dq_on_die_termination(dq_on_die_termination),
   .mask_on_die_termination(mask_on_die_termination),
   .dll_locked(dll_locked), .refresh_strobe(refresh_strobe));

// File: testbench/lldr_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   n_tests++; \
   if ((g) !== (e)) begin \
      bad_count++; \
      $display("ERROR %s exp %0h got %0h", nm, e, g); \
   end \
end
module lldr_tb_top
   import lldr_pkg::*;
;
   typedef struct {logic [17:0] r; logic [17:0] f; int c;} lldr_note_t;
   lldr_note_t q[$];
   logic [2:0] rq[$];
   logic sys_clk = 0, link_clk = 0, rst = 1, mr = 0, mf = 0;
   logic flt = 0, cmp = 1, read_data_clock, addr_mux_mode;
   logic [17:0] wr_r = 0, wr_f = 0, read_data_rise, read_data_fall;
   logic [17:0] mem [256];
   logic cs_n, we_n, ref_n, read_data_oe, read_data_valid, read_data_clock_n;
   logic dq_on_die_termination, mask_on_die_termination, impedance_ball_sel;
   logic dll_enabled, dll_locked, refresh_strobe;
   logic [ADDR_W-1:0] addr;
   logic [2:0] bank, refresh_bank;
   logic [5:0] drive_code;
   int cyc = 0, bad_count = 0, n_tests = 0, rl, nb, k;
   int rl_tab [6] = '{4, 4, 6, 8, 3, 5};
   logic [1:0] bls [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2};
   integer seed = 32'haa3244d9;
   initial forever #50 sys_clk = ~sys_clk;
   initial begin
      #7;
      forever #15 link_clk = ~link_clk;
   end
   lldr_ctrl_model ctl (.link_clk, .cs_n, .we_n, .ref_n, .addr, .bank);
   lldr_top dut (.sys_clk, .rst, .link_clk, .cs_n, .we_n, .ref_n, .addr,
      .bank, .write_data_rise(wr_r), .write_data_fall(wr_f),
      .write_mask_rise(mr), .write_mask_fall(mf), .clock_fault(flt),
      .impedance_resistor_cmp(cmp), .read_data_rise, .read_data_fall,
      .read_data_oe, .read_data_valid, .read_data_clock,
      .read_data_clock_n, .dq_on_die_termination, .mask_on_die_termination,
      .impedance_ball_sel, .drive_code, .dll_enabled, .dll_locked,
      .addr_mux_mode, .refresh_strobe, .refresh_bank);
   // Comparator wanders so calibration keeps stepping in the background
   always @(posedge sys_clk) begin
      #1 cmp = $random(seed);
   end
   always @(posedge link_clk) begin
      lldr_note_t n;
      cyc <= cyc + 1;
      if (refresh_strobe === 1'b1) rq.push_back(refresh_bank);
      if (read_data_oe === 1'b1) begin
         `CHK("queued", 1'b1, q.size() != 0)
         if (q.size() != 0) begin
            n = q.pop_front();
            `CHK("cycle", n.c, cyc)
            `CHK("rise", n.r, read_data_rise)
            `CHK("fall", n.f, read_data_fall)
         end
      end
   end
   task automatic ms(input logic [2:0] c, input logic [1:0] bl, input logic x);
      ctl.op(2'b00, {12'h000, 4'hE, x, bl, c}, '0, 3'h0, 1'b0);
      ctl.idle(4);
      `CHK("loop", 1'b1, dll_enabled)
      `CHK("mux", x, addr_mux_mode)
      `CHK("term", 2'h3, {dq_on_die_termination, mask_on_die_termination})
      rl = rl_tab[c] + x;
      nb = 1 << bl;
   endtask : ms
   // Index bits 1 and 2 ride on the second part in multiplexed mode
   task automatic acc(input logic [1:0] c, input logic [4:0] a,
                      input logic [2:0] b, input logic x);
      logic [31:0] r1, r2;
      lldr_note_t n;
      r1 = $random(seed);
      r2 = $random(seed);
      ctl.op(c, r1[21:0] & 22'h3FFFE0 | {17'h0, a},
             r2[21:0] & 22'h3FFFE7 | {17'h0, a[2:1], 3'h0}, b, x);
      for (int i = 0; i < nb; i++) begin
         if (c == 2'b01) begin
            if (!mr) mem[{b, a} + 2 * i] = wr_r;
            if (!mf) mem[{b, a} + 2 * i + 1] = wr_f;
         end else begin
            n.r = mem[{b, a} + 2 * i];
            n.f = mem[{b, a} + 2 * i + 1];
            n.c = cyc + 1 + rl - x + i;
            q.push_back(n);
         end
      end
   endtask : acc
   task automatic trip(input logic x);
      logic [31:0] r;
      r = $random(seed);
      {wr_r, wr_f} = {r[17:0], r[31:14]};
      acc(2'b01, {r[4:3], 3'h0}, r[7:5], x);
      ctl.idle(14);
      {wr_r, wr_f} = {r[31:14], r[17:0] ^ 18'h2A5A5};
      {mr, mf} = r[9:8];
      acc(2'b01, {r[4:3], 3'h0}, r[7:5], x);
      ctl.idle(14);
      acc(2'b11, {r[4:3], 3'h0}, r[7:5], x);
      if (nb > 1 + x) ctl.idle(nb - 1 - x);
      acc(2'b11, {r[4:3], 3'h0}, r[7:5], x);
      ctl.idle(20);
   endtask : trip
   task automatic final_report;
      $display("Tests %0d errors %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report
   initial begin
      #200000;
      bad_count++;
      final_report();
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      `CHK("code", 6'h20, drive_code)
      `CHK("qk_n", 1'b1, read_data_clock_n)
      `CHK("qk", 1'b0, read_data_clock)
      #1 rst = 1'b0;
      ctl.idle(5);
      `CHK("loop_rst", 2'h0, {dll_enabled, dll_locked})
      ms(3'h0, 2'h0, 1'b0);
      ctl.idle(1030);
      `CHK("locked", 1'b1, dll_locked)
      `CHK("ext_ref", 1'b1, impedance_ball_sel)
      for (k = 0; k < 6; k++) begin
         ms(k[2:0], bls[k], 1'b0);
         trip(1'b0);
      end
      ms(3'h3, 2'h1, 1'b1);
      trip(1'b1);
      ctl.op(2'b10, '0, '0, 3'h5, 1'b0);
      ctl.op(2'b10, '0, '0, 3'h2, 1'b0);
      ctl.idle(10);
      `CHK("refresh", 7'h6A, {rq.size() == 2, rq[0], rq[1]})
      `CHK("pending", 0, q.size())
      final_report();
   end
endmodule : lldr_tb_top
